/* logic/irv_ctrl.sv */
// Function
// - Source events set flags regardless of masking
// - Maskable request needs own enable and master
// - Software writing one raises the interrupt
// - Acceptance clears the accepted source flag
// - Register seven bit zero latches sixteen hertz
// - Register seven bit three latches two hertz
// - Request or enable register write delays entry one more instruction
// - Twenty-three masked sources, watchdog and pin bypass
// - Accepted source fetches its fixed vector, shifts
// - Watchdog, pin, slow clock: priorities and vectors
// - Serial ports and converter vectors and priorities
// - Highest priority first, lower ones stay pending
// - Maskable entry saves level one, clears master
// - Non-maskable entry saves level two, keeps master
// - Software trap uses level one, operand vector
// - No acceptance before handler first instruction
// - No acceptance right after data segment prefix
`timescale 1ns/1ns
`default_nettype none
module irv_ctrl
  import irv_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire irv_bus_t           bus_i,
  output logic [7:0]              rd_data_o,
  input  wire logic               watchdog_event_i,
  input  wire logic               nonmaskable_pin_i,
  input  wire logic [MASK_CNT-1:0] periph_evt_i,
  input  wire irv_ctx_t           ctx_i,
  input  wire logic               instr_done_i,
  input  wire logic               dsr_prefix_i,
  input  wire logic               trap_i,
  input  wire logic [5:0]         trap_idx_i,
  input  wire logic               rti_i,
  output logic                    shift_o,
  output logic [15:0]             vec_addr_o,
  output logic                    pending_o,
  output logic [15:0]             pend_vec_o,
  output irv_ctx_t                save1_o,
  output irv_ctx_t                save2_o,
  output logic [1:0]              exception_level_o,
  output logic                    master_irq_enable_o,
  output logic                    irq_o
);

  // Pin synchroniser and edge detector; the edge detect reads only stage two and three
  logic                 nmi_s1_r;          // First stage, read by stage two only
  logic                 nmi_s2_r;          // Second stage
  logic                 nmi_s3_r;          // Delayed copy for edge detect
  // Flag and enable state
  logic [NSRC-1:0]      flag_r;            // Request flags, one per source
  logic [NSRC-1:0]      flag_nxt;
  logic [NSRC-1:0]      en_r;              // Enables; the two non-maskable stay unused
  logic [NSRC-1:0]      en_nxt;
  logic [NSRC-1:0]      evt;               // Event pulses in priority order
  logic [NSRC-1:0]      elig;              // Flags allowed to request
  logic                 master_r;          // Master enable
  logic                 master_nxt;
  // Entry control
  logic                 shift_r;           // Shift cycle pulse
  logic [15:0]          vec_r;             // Vector being loaded
  irv_entry_t           kind_r;            // Kind of the last entry
  irv_entry_t           kind_nxt;
  logic                 defer_r;           // One more instruction before entry
  logic                 defer_nxt;
  irv_ctx_t             save1_r;
  irv_ctx_t             save2_r;
  logic [1:0]           level_r;
  logic [1:0]           level_nxt;
  logic                 pend_r;
  logic [15:0]          pend_vec_r;
  // Interrupt status
  logic [2:0]           stat_r;
  logic [2:0]           stat_nxt;
  logic [2:0]           mask_r;
  logic                 irq_r;
  logic [7:0]           rd_data_r;
  logic [7:0]           rd_nxt;
  // Decode
  logic [SRC_W-1:0]     sel_idx;           // Highest priority eligible source
  logic                 any_elig;
  logic                 sel_nmi;
  logic                 req_hit;
  logic                 en_hit;
  logic [2:0]           reg_num;
  logic                 cfg_wr;
  logic                 master_wr;
  logic                 mask_wr;
  logic                 stat_rd;
  logic                 take_ok;
  logic                 hw_take;
  logic                 sw_take;
  logic                 go;
  logic [15:0]          go_vec;
  logic [7:0]           req_view [8];
  logic [7:0]           en_view [8];

  // Lowest index wins, so the loop walks from the bottom of the table upward
  function automatic logic [SRC_W-1:0] irv_pick(input logic [NSRC-1:0] e);
    logic [SRC_W-1:0] p;
    p = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (e[i]) begin
        p = SRC_W'(i);
      end
    end
    return p;
  endfunction : irv_pick

  // Address decode
  assign reg_num  = bus_i.addr[2:0];
  assign req_hit  = (bus_i.addr[15:3] == REQ_BASE_ADDR[15:3]);
  assign en_hit   = (bus_i.addr[15:3] == EN_BASE_ADDR[15:3]);
  assign cfg_wr   = bus_i.wr & (req_hit | en_hit);
  assign master_wr = bus_i.wr & (bus_i.addr == MASTER_ADDR);
  assign mask_wr  = bus_i.wr & (bus_i.addr == MASK_ADDR);
  assign stat_rd  = bus_i.rd & (bus_i.addr == STAT_ADDR);

  // Event vector: watchdog, pin edge, then peripherals
  assign evt = {periph_evt_i, nmi_s2_r & ~nmi_s3_r, watchdog_event_i};

  // Non-maskable flags always request; others need both enables
  assign elig     = flag_r & ({{MASK_CNT{master_r}}, {NMI_CNT{1'b1}}} &
                              (en_r | {{MASK_CNT{1'b0}}, {NMI_CNT{1'b1}}}));
  assign any_elig = |elig;
  assign sel_idx  = irv_pick(elig);
  assign sel_nmi  = (sel_idx < SRC_W'(NMI_CNT));

  // Acceptance only at an instruction boundary outside the blocked windows
  assign take_ok = instr_done_i & ~dsr_prefix_i & ~shift_r
                 & ~defer_r & ~cfg_wr;
  assign sw_take = trap_i & ~shift_r;
  assign hw_take = take_ok & any_elig & ~sw_take;
  assign go      = hw_take | sw_take;
  // Software trap vector table is two bytes per entry
  assign go_vec  = sw_take ? {9'h000, trap_idx_i, 1'b0} : SRC_VEC[sel_idx];

  // Per source flag: event or software set wins over the acceptance clear
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    logic wr_this;
    logic en_this;
    assign wr_this = req_hit & bus_i.wr & (reg_num == SRC_REG[g]);
    assign en_this = en_hit & bus_i.wr & (reg_num == SRC_REG[g]);
    assign flag_nxt[g] = evt[g]
                       | (wr_this ? bus_i.wdata[SRC_BIT[g]]
                                  : (flag_r[g] & ~(hw_take & (sel_idx == SRC_W'(g)))));
    assign en_nxt[g] = en_this ? bus_i.wdata[SRC_BIT[g]] : en_r[g];
  end

  // Gather flags and enables into their byte views
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      req_view[r] = REG_RESET;
      en_view[r]  = REG_RESET;
    end
    for (int i = 0; i < NSRC; i++) begin
      req_view[SRC_REG[i]][SRC_BIT[i]] = flag_r[i];
      en_view[SRC_REG[i]][SRC_BIT[i]]  = en_r[i];
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rd_nxt = REG_RESET;
    if (bus_i.rd) begin
      if (req_hit) begin
        rd_nxt = req_view[reg_num];
      end else if (en_hit) begin
        rd_nxt = en_view[reg_num];
      end else if (bus_i.addr == MASTER_ADDR) begin
        rd_nxt = {7'h00, master_r};
      end else if (bus_i.addr == LEVEL_ADDR) begin
        rd_nxt = {6'h00, level_r};
      end else if (bus_i.addr == STAT_ADDR) begin
        rd_nxt = {5'h00, stat_r};
      end else if (bus_i.addr == MASK_ADDR) begin
        rd_nxt = {5'h00, mask_r};
      end else begin
        rd_nxt = REG_RESET;
      end
    end
  end

  // Entry kind, level, master enable and status updates
  always_comb begin
    kind_nxt  = IRV_NONE;
    if (sw_take) begin
      kind_nxt = IRV_SOFT;
    end else if (hw_take) begin
      kind_nxt = sel_nmi ? IRV_NONMASK : IRV_MASKABLE;
    end
    level_nxt = level_r;
    master_nxt = master_wr ? bus_i.wdata[0] : master_r;
    // Read clears, but a new entry in the same cycle still sets its bit
    stat_nxt  = stat_rd ? 3'h0 : stat_r;
    case (kind_nxt)
      IRV_MASKABLE: begin
        level_nxt = LEVEL_ONE;
        master_nxt = 1'b0;
        stat_nxt[ST_MASK_BIT] = 1'b1;
      end
      IRV_SOFT: begin
        level_nxt = LEVEL_ONE;
        master_nxt = 1'b0;
        stat_nxt[ST_TRAP_BIT] = 1'b1;
      end
      IRV_NONMASK: begin
        level_nxt = LEVEL_TWO;
        master_nxt = master_r;
        stat_nxt[ST_NMI_BIT] = 1'b1;
      end
      IRV_NONE: begin
        // Return drops one level; the core restores its own status word
        if (rti_i && level_r != LEVEL_RESET) begin
          level_nxt = level_r - LEVEL_ONE;
        end
      end
      default: begin
        level_nxt = level_r;
      end
    endcase
  end

  // A write to a request or enable register lets one further instruction pass
  assign defer_nxt = cfg_wr ? ~instr_done_i
                            : (defer_r & ~instr_done_i);

  // Pin synchroniser
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_s3_r <= 1'b0;
    end else begin
      nmi_s1_r <= nonmaskable_pin_i;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
    end
  end

  // Flags, enables, master enable and deferral
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_r  <= '0;
      en_r    <= '0;
      master_r <= MASTER_RESET;
      defer_r <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      en_r    <= en_nxt;
      master_r <= master_nxt;
      defer_r <= defer_nxt;
    end
  end

  // Shift cycle and vector load
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_r <= 1'b0;
      vec_r   <= 16'h0000;
      kind_r  <= IRV_NONE;
      level_r <= LEVEL_RESET;
    end else begin
      shift_r <= go;
      vec_r   <= go ? go_vec : vec_r;
      kind_r  <= go ? kind_nxt : kind_r;
      level_r <= level_nxt;
    end
  end

  // Context save: level one for maskable and software, level two for non-maskable
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      save1_r <= '0;
      save2_r <= '0;
    end else begin
      if (kind_nxt == IRV_MASKABLE || kind_nxt == IRV_SOFT) begin
        save1_r <= ctx_i;
      end
      if (kind_nxt == IRV_NONMASK) begin
        save2_r <= ctx_i;
      end
    end
  end

  // Pending request view, registered from the eligible flags every cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_r     <= 1'b0;
      pend_vec_r <= 16'h0000;
    end else begin
      pend_r     <= any_elig;
      pend_vec_r <= any_elig ? SRC_VEC[sel_idx] : 16'h0000;
    end
  end

  // Entry status, mask and interrupt line
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_r    <= 3'h0;
      mask_r    <= 3'h0;
      irq_r     <= 1'b0;
      rd_data_r <= REG_RESET;
    end else begin
      stat_r    <= stat_nxt;
      mask_r    <= mask_wr ? bus_i.wdata[2:0] : mask_r;
      // Uses the incoming mask so the line follows a mask write without lag
      irq_r     <= |(stat_nxt & (mask_wr ? bus_i.wdata[2:0] : mask_r));
      rd_data_r <= rd_nxt;
    end
  end

  assign rd_data_o           = rd_data_r;
  assign shift_o             = shift_r;
  assign vec_addr_o          = vec_r;
  assign pending_o           = pend_r;
  assign pend_vec_o          = pend_vec_r;
  assign save1_o             = save1_r;
  assign save2_o             = save2_r;
  assign exception_level_o   = level_r;
  assign master_irq_enable_o = master_r;
  assign irq_o               = irq_r;

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [NSRC-1:0] higher_mask;                    // Sources ranked above the pick
  assign higher_mask = (NSRC'(1) << sel_idx) - NSRC'(1);

  tb16_event_sets_a: assert property (evt[TB16_IDX] |=> flag_r[TB16_IDX] &&
                                      req_view[REG_LAST][0])
    else $error("16 Hz event did not set its flag");
  tb2_event_sets_a: assert property (evt[TB2_IDX] |=> req_view[REG_LAST][3])
    else $error("2 Hz event did not set its flag");
  masked_gate_a: assert property (hw_take && !sel_nmi |-> master_r && en_r[sel_idx])
    else $error("Masked source was accepted");
  sw_write_set_a: assert property (bus_i.wr && bus_i.addr == REQ7_ADDR &&
                                   bus_i.wdata[0] |=> flag_r[TB16_IDX])
    else $error("Software set of flag lost");
  accept_clears_a: assert property (hw_take && !evt[sel_idx] |=>
                                    !flag_r[$past(sel_idx)])
    else $error("Accepted flag not cleared");
  write_defer_a: assert property (hw_take |-> !defer_r && !cfg_wr)
    else $error("Entry too soon after register write");
  watchdog_vec_a: assert property (hw_take && sel_idx == 0 |=>
                                   shift_r && vec_r == SRC_VEC[0])
    else $error("Watchdog vector wrong");
  serial_vec_a: assert property (hw_take && sel_idx == 7 |=>
                                 vec_r == SRC_VEC[7] && kind_r == IRV_MASKABLE)
    else $error("Serial port vector wrong");
  priority_order_a: assert property (hw_take |-> (elig & higher_mask) == '0)
    else $error("Lower priority source taken first");
  mask_entry_a: assert property (hw_take && !sel_nmi |=> level_r == LEVEL_ONE
                                 && !master_r && save1_r == $past(ctx_i))
    else $error("Maskable entry sequence wrong");
  nmi_entry_a: assert property (hw_take && sel_nmi && !master_wr |=>
                                level_r == LEVEL_TWO && master_r == $past(master_r))
    else $error("Non-maskable entry sequence wrong");
  soft_entry_a: assert property (sw_take |=> vec_r == {9'h000, $past(trap_idx_i), 1'b0}
                                 && level_r == LEVEL_ONE && !master_r)
    else $error("Software trap entry wrong");
  shift_block_a: assert property (shift_r |-> !hw_take)
    else $error("Accepted during shift cycle");
  prefix_block_a: assert property (instr_done_i && dsr_prefix_i |-> !hw_take)
    else $error("Accepted after prefix");
  pend_view_a: assert property (any_elig && !hw_take |=> pend_r &&
                                pend_vec_r == SRC_VEC[$past(sel_idx)])
    else $error("Pending vector not presented");

  cov_nmi_c:   cover property (hw_take && sel_nmi);
  cov_tb2_c:   cover property (hw_take && sel_idx == SRC_W'(TB2_IDX));
  cov_swi_c:   cover property (sw_take);
  cov_defer_c: cover property (cfg_wr ##1 instr_done_i ##[1:20] hw_take);

endmodule : irv_ctrl
`default_nettype wire

/* logic/irv_pkg.sv */
`default_nettype none
package irv_pkg;
  // Source count: watchdog, pin NMI, then 23 maskable sources in priority order
  localparam int NSRC     = 25;
  localparam int NMI_CNT  = 2;
  localparam int MASK_CNT = 23;
  localparam int SRC_W    = 5;

  // Register map, one byte per address
  localparam logic [15:0] REQ_BASE_ADDR = 16'hF018;  // Request register n at base plus n
  localparam logic [15:0] REQ7_ADDR     = 16'hF01F;  // Time base request flags
  localparam logic [15:0] EN_BASE_ADDR  = 16'hF010;  // Enable register n at base plus n
  localparam logic [15:0] MASTER_ADDR   = 16'hF008;  // Master enable, bit 0
  localparam logic [15:0] LEVEL_ADDR    = 16'hF009;  // Exception level, read only
  localparam logic [15:0] STAT_ADDR     = 16'hF00A;  // Entry status, cleared by read
  localparam logic [15:0] MASK_ADDR     = 16'hF00B;  // Entry status mask
  localparam logic [2:0]  REG_LAST      = 3'h7;      // Highest request register number

  // Reset values
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic        MASTER_RESET  = 1'b0;
  localparam logic [1:0]  LEVEL_RESET   = 2'h0;
  localparam logic [1:0]  LEVEL_ONE     = 2'h1;
  localparam logic [1:0]  LEVEL_TWO     = 2'h2;

  // Entry status bit positions
  localparam int ST_MASK_BIT = 0;
  localparam int ST_NMI_BIT  = 1;
  localparam int ST_TRAP_BIT = 2;

  // Time base source indices
  localparam int TB16_IDX = 23;
  localparam int TB2_IDX  = 24;

  // Register number, bit position and vector of each source, index order is priority order
  localparam logic [2:0] SRC_REG [NSRC] = '{
    3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3,
    3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6, 3'h7, 3'h7};
  localparam logic [2:0] SRC_BIT [NSRC] = '{
    3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h7, 3'h0, 3'h1,
    3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h0, 3'h1, 3'h5, 3'h7, 3'h0, 3'h3};
  localparam logic [15:0] SRC_VEC [NSRC] = '{
    16'h0008, 16'h000A, 16'h000C, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
    16'h0020, 16'h0022, 16'h0024, 16'h002E, 16'h0030, 16'h0032, 16'h0034,
    16'h0036, 16'h0040, 16'h0042, 16'h005C, 16'h005E, 16'h0060, 16'h0062,
    16'h006A, 16'h006E, 16'h0070, 16'h0076};

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } irv_bus_t;

  // Processor context saved on entry
  typedef struct packed {
    logic [15:0] pc;
    logic [3:0]  code_segment_reg;
    logic [7:0]  processor_status_word;
  } irv_ctx_t;

  // Kind of entry sequence
  typedef enum logic [1:0] {
    IRV_NONE     = 2'b00,
    IRV_MASKABLE = 2'b01,
    IRV_NONMASK  = 2'b10,
    IRV_SOFT     = 2'b11
  } irv_entry_t;
endpackage : irv_pkg
`default_nettype wire

/* verification/irv_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Core stand-in: one instruction completes per cycle while go is high
module irv_core_model
  import irv_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        go_i,
  input  wire logic [7:0]  psw_i,
  input  wire logic        shift_i,
  input  wire logic [15:0] vec_i,
  output logic             instr_done_o,
  output irv_ctx_t         ctx_o,
  output irv_ctx_t         prev_ctx_o
);
  logic [15:0] pc_r;  // Program counter of the running code

  // Completion follows go, which the bench moves just after an edge
  assign instr_done_o = go_i;
  // Segment tracks the pc so that a wrong save shows up
  assign ctx_o = {pc_r, pc_r[4:1], psw_i};

  // Jump to the vector on a shift, otherwise step over each instruction
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_r       <= 16'h0100;
      prev_ctx_o <= '0;
    end else begin
      prev_ctx_o <= ctx_o;  // Context as the block saw it at this edge
      if (shift_i) begin
        pc_r <= vec_i;
      end else if (go_i) begin
        pc_r <= pc_r + 16'h0002;
      end
    end
  end
endmodule : irv_core_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench
  import irv_pkg::*;
;
  logic        clk_i = 1'b0;  // 250 MHz system clock
  logic        rst_b_i = 1'b0;
  irv_bus_t    bus = '0;
  logic        wdog = 1'b0, nmi = 1'b0, dsr = 1'b0, trap = 1'b0, rti = 1'b0, go = 1'b0;
  logic [22:0] pev = '0;  // Peripheral event pulses
  logic [5:0]  sidx = '0;
  logic [7:0]  processor_status_word = '0, rd;
  logic        shift, pend, master, irq, done;
  logic [15:0] vec, pvec;
  logic [1:0]  lvl;
  irv_ctx_t    ctx, pctx, save1, save2;
  int          mismatches = 0, n_tests = 0, n, e;
  bit          mflag [NSRC];  // Bench copy of the pending flags
  logic [7:0]  d;

  always #2 clk_i = ~clk_i;

  irv_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rd_data_o(rd),
    .watchdog_event_i(wdog), .nonmaskable_pin_i(nmi), .periph_evt_i(pev), .ctx_i(ctx),
    .instr_done_i(done), .dsr_prefix_i(dsr), .trap_i(trap), .trap_idx_i(sidx), .rti_i(rti),
    .shift_o(shift), .vec_addr_o(vec), .pending_o(pend), .pend_vec_o(pvec),
    .save1_o(save1), .save2_o(save2), .exception_level_o(lvl),
    .master_irq_enable_o(master), .irq_o(irq));
  irv_core_model core (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .psw_i(processor_status_word),
    .shift_i(shift), .vec_i(vec), .instr_done_o(done), .ctx_o(ctx), .prev_ctx_o(pctx));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(logic [15:0] a, logic [7:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(string nm, logic [15:0] a, logic [7:0] exp);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    @(negedge clk_i);
    chk(nm, rd, exp);
  endtask : rdchk

  // Bounded wait, n counts the quiet cycles before the shift
  task automatic wait_shift(output int cnt);
    for (cnt = 0; cnt < 40; cnt++) begin
      @(negedge clk_i);
      if (shift === 1'b1) break;
    end
    if (cnt == 40) begin
      chk("shift_o", 1'b0, 1'b1);
      complete_run();
    end
  endtask : wait_shift

  // Let the core run, the first completion optionally a segment prefix
  // Starts on a rising edge so go never moves in mid-cycle
  task automatic run(logic pfx, output int cnt);
    @(posedge clk_i);
    go <= 1'b1;
    dsr <= pfx;
    @(posedge clk_i);
    dsr <= 1'b0;
    wait_shift(cnt);
  endtask : run

  task automatic chk_entry(logic [15:0] v, logic [1:0] l, logic m, logic two);
    chk("vec_addr_o", vec, v);
    chk("exception_level_o", lvl, l);
    chk("master_irq_enable_o", master, m);
    chk("saved context", two ? save2 : save1, pctx);
  endtask : chk_entry

  // Highest pending source in the bench copy; index order is priority
  function automatic int best();
    for (int i = 0; i < NSRC; i++) if (mflag[i]) return i;
    return -1;
  endfunction : best

  // Vectors fixed for the named sources, the rest from the table
  function automatic logic [15:0] lit_vec(int i);
    case (i)
      0: return 16'h0008;
      1: return 16'h000A;
      2: return 16'h000C;
      7: return 16'h0020;
      8: return 16'h0022;
      9: return 16'h0024;
      default: return SRC_VEC[i];
    endcase
  endfunction : lit_vec

  initial begin
    void'($urandom(80398));
    processor_status_word <= 8'($urandom);
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdchk("time base flags", REQ7_ADDR, 8'h00);
    chk("exception_level_o", lvl, LEVEL_RESET);
    // Time base events set flags with every enable off
    @(posedge clk_i);
    pev[TB16_IDX-2] <= 1'b1;
    pev[TB2_IDX-2] <= 1'b1;
    @(posedge clk_i);
    pev <= '0;
    rdchk("time base flags", REQ7_ADDR, 8'h09);
    chk("pending_o", pend, 1'b0);
    // Software raise, due because of a request write
    wr(REQ7_ADDR, 8'h00);
    wr(EN_BASE_ADDR + 16'h0007, 8'h09);
    wr(MASTER_ADDR, 8'h01);
    d = 8'($urandom) | 8'h09;
    wr(REQ7_ADDR, d);
    run(1'b0, n);
    chk("cycles to shift", n, 1);
    chk_entry(16'h0070, LEVEL_ONE, 1'b0, 1'b0);
    @(posedge clk_i);
    go <= 1'b0;
    rdchk("time base flags", REQ7_ADDR, 8'h08);
    // Prefix completion must not let the two hertz request in
    wr(MASTER_ADDR, 8'h01);
    run(1'b1, n);
    chk("cycles to shift", n, 1);
    chk("vec_addr_o", vec, 16'h0076);
    @(posedge clk_i);
    go <= 1'b0;
    // Software trap with a random operand
    @(posedge clk_i);
    trap <= 1'b1;
    sidx <= 6'($urandom);
    @(posedge clk_i);
    trap <= 1'b0;
    wait_shift(n);
    chk("cycles to shift", n, 0);
    chk_entry({9'h000, sidx, 1'b0}, LEVEL_ONE, 1'b0, 1'b0);
    rdchk("exception level", LEVEL_ADDR, 8'h01);
    rdchk("master enable", MASTER_ADDR, 8'h00);
    rdchk("enable seven", EN_BASE_ADDR + 16'h0007, 8'h09);
    rdchk("entry status", STAT_ADDR, 8'h05);
    // Every source at once; master on, individual enables off
    wr(EN_BASE_ADDR + 16'h0007, 8'h00);
    wr(MASTER_ADDR, 8'h01);
    wr(MASK_ADDR, 8'h02);
    @(posedge clk_i);
    wdog <= 1'b1;
    nmi <= 1'b1;
    pev <= '1;
    foreach (mflag[i]) mflag[i] = 1'b1;
    @(posedge clk_i);
    wdog <= 1'b0;
    pev <= '0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("pending_o", pend, 1'b1);
    chk("pend_vec_o", pvec, 16'h0008);
    for (int k = 0; k < NSRC; k++) begin
      if (k >= 2) begin
        @(posedge clk_i);
        go <= 1'b0;
      end
      if (k == 2) begin
        repeat (4) @(negedge clk_i);
        chk("pending_o", pend, 1'b0);
        chk("irq_o", irq, 1'b1);
        rdchk("entry status", STAT_ADDR, 8'h02);
        chk("irq_o", irq, 1'b0);
        for (int j = 0; j <= REG_LAST; j++) wr(EN_BASE_ADDR + 16'(j), 8'hFF);
      end
      if (k > 2) wr(MASTER_ADDR, 8'h01);
      if (k == 1) begin
        wait_shift(n);
        chk("cycles to shift", n, 1);
      end else begin
        run(1'b0, n);
      end
      e = best();
      chk_entry(lit_vec(e), e < 2 ? LEVEL_TWO : LEVEL_ONE, e < 2, e < 2);
      mflag[e] = 1'b0;
    end
    @(posedge clk_i);
    go <= 1'b0;
    rdchk("time base flags", REQ7_ADDR, 8'h00);
    chk("pending_o", pend, 1'b0);
    chk("irq_o", irq, 1'b0);
    rdchk("entry status", STAT_ADDR, 8'h01);
    rdchk("entry mask", MASK_ADDR, 8'h02);
    rdchk("unmapped", 16'hF0F0, 8'h00);
    // A request write whose own instruction completes lets the next one take
    wr(MASTER_ADDR, 8'h01);
    go <= 1'b1;
    wr(REQ7_ADDR, 8'h01);
    wait_shift(n);
    chk("cycles to shift", n, 1);
    chk("vec_addr_o", vec, 16'h0070);
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    rti <= 1'b1;
    @(posedge clk_i);
    rti <= 1'b0;
    @(negedge clk_i);
    chk("exception_level_o", lvl, LEVEL_RESET);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
